// ---- design/dsm_params.svh ----
`ifndef DSM_PARAMS_SVH
`define DSM_PARAMS_SVH

// Serial bus address of this device; the value is arbitrary.
`define DSM_I2C_ADDR 7'h55

// Register offsets.
`define DSM_REG_HS_LOW 8'h17
`define DSM_REG_PACKED 8'h18
`define DSM_REG_FB_B0 8'h1a
`define DSM_REG_FB_B1 8'h1b
`define DSM_REG_FB_B2 8'h1c
`define DSM_REG_FB_B3 8'h1d
`define DSM_REG_FB_B4 8'h1e
`define DSM_REG_FB_TOP 8'h1f

// Field widths and positions.
`define DSM_HS_W 11
`define DSM_LS_W 3
`define DSM_FB_INT_W 11
`define DSM_FB_FRAC_W 32
`define DSM_FB_W 43
`define DSM_PK_LS_MSB 6
`define DSM_PK_LS_LSB 4
`define DSM_PK_HS_MSB 2
`define DSM_PK_HS_LSB 0
`define DSM_LS_MAX_EXP 3'h5

// Reset values of the divider settings.
`define DSM_HS_RESET 11'h046
`define DSM_LS_RESET 3'h0
`define DSM_FB_RESET 43'h047e756e62a

// Unmapped registers read as this value.
`define DSM_UNMAPPED_READ 8'h00

`endif

// ---- design/dsm_pkg.sv ----
`include "dsm_params.svh"

package dsm_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_REG,
    ST_REG_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK
  } dsm_state_e;

  typedef struct packed {
    logic scl_meta;
    logic scl_sync;
    logic scl_prev;
    logic sda_meta;
    logic sda_sync;
    logic sda_prev;
  } dsm_sync_s;

  typedef struct packed {
    dsm_state_e state;
    logic [7:0] shreg;
    logic [3:0] bitcnt;
    logic [7:0] ptr;
    logic rw;
    logic sda_oe;
    logic [`DSM_HS_W-1:0] hs;
    logic [`DSM_LS_W-1:0] ls;
    logic [`DSM_FB_W-1:0] fb;
    logic [`DSM_HS_W-1:0] hs_out;
    logic [5:0] ls_ratio_out;
    logic [`DSM_FB_INT_W-1:0] fb_int_out;
    logic [`DSM_FB_FRAC_W-1:0] fb_frac_out;
    logic [15:0] total_div_out;
  } dsm_top_s;

endpackage

// ---- design/dsm_sync_if.sv ----
`timescale 1ns/1ns
`default_nettype none

interface dsm_sync_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda;

  modport src (
    output scl_rise,
    output scl_fall,
    output start,
    output stop,
    output sda
  );

  modport snk (
    input scl_rise,
    input scl_fall,
    input start,
    input stop,
    input sda
  );
endinterface

`default_nettype wire

// ---- design/dsm_bus_sync.sv ----
`timescale 1ns/1ns
`default_nettype none

module dsm_bus_sync
  import dsm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  dsm_sync_if.src ev
);

  dsm_sync_s s_reg;
  dsm_sync_s s_next;

  // Idle bus is high, so the chain resets high to avoid a false start.
  always_comb begin
    s_next = s_reg;
    s_next.scl_meta = scl_in;
    s_next.scl_sync = s_reg.scl_meta;
    s_next.scl_prev = s_reg.scl_sync;
    s_next.sda_meta = sda_in;
    s_next.sda_sync = s_reg.sda_meta;
    s_next.sda_prev = s_reg.sda_sync;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign ev.scl_rise = s_reg.scl_sync & ~s_reg.scl_prev;
  assign ev.scl_fall = ~s_reg.scl_sync & s_reg.scl_prev;
  assign ev.start = s_reg.scl_sync & s_reg.scl_prev & s_reg.sda_prev & ~s_reg.sda_sync;
  assign ev.stop = s_reg.scl_sync & s_reg.scl_prev & ~s_reg.sda_prev & s_reg.sda_sync;
  assign ev.sda = s_reg.sda_sync;

endmodule

`default_nettype wire

// ---- design/dsm_top.sv ----
// What this block does
// - Feedback divider is unsigned 11.32 fixed point.
// - Packed register: exponent 6:4, high divider 2:0.
// - Packed bits 7 and 3 unused, no effect.
// - High low byte 23; feedback 26-31 little-endian.
// - Low divider is two to the stored exponent.
// - Output equals oscillator over both dividers.
// - Settings work unchanged on faster grades.
// - Exponents six and seven act as five.
`timescale 1ns/1ns
`default_nettype none

module dsm_top
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic [10:0] high_speed_divider,
  output logic [5:0] low_speed_divider_ratio,
  output logic [10:0] feedback_integer_part,
  output logic [31:0] feedback_fraction_part,
  output logic [15:0] total_output_divide
);
  import dsm_pkg::*;

  localparam dsm_top_s TOP_RESET = '{
    state: ST_IDLE,
    shreg: 8'h00,
    bitcnt: 4'h0,
    ptr: 8'h00,
    rw: 1'b0,
    sda_oe: 1'b0,
    hs: `DSM_HS_RESET,
    ls: `DSM_LS_RESET,
    fb: `DSM_FB_RESET,
    hs_out: 11'h000,
    ls_ratio_out: 6'h00,
    fb_int_out: 11'h000,
    fb_frac_out: 32'h00000000,
    total_div_out: 16'h0000
  };

  logic rst_meta_reg;
  logic rst_n_reg;
  dsm_top_s t_reg;
  dsm_top_s t_next;

  dsm_sync_if ev ();

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  dsm_bus_sync u_sync (
    .clock(clock),
    .rst_n(rst_n_reg),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ev(ev.src)
  );

  // Exponents above the largest stage saturate there.
  function automatic logic [2:0] ls_exp(input logic [2:0] e);
    ls_exp = (e > `DSM_LS_MAX_EXP) ? `DSM_LS_MAX_EXP : e;
  endfunction

  // Register read view; unused packed bits read as zero.
  function automatic logic [7:0] read_byte(
    input logic [7:0] a,
    input logic [10:0] hs,
    input logic [2:0] ls,
    input logic [42:0] fb
  );
    unique case (a)
      `DSM_REG_HS_LOW: read_byte = hs[7:0];
      `DSM_REG_PACKED: read_byte = {1'b0, ls, 1'b0, hs[10:8]};
      `DSM_REG_FB_B0: read_byte = fb[7:0];
      `DSM_REG_FB_B1: read_byte = fb[15:8];
      `DSM_REG_FB_B2: read_byte = fb[23:16];
      `DSM_REG_FB_B3: read_byte = fb[31:24];
      `DSM_REG_FB_B4: read_byte = fb[39:32];
      `DSM_REG_FB_TOP: read_byte = {5'h00, fb[42:40]};
      default: read_byte = `DSM_UNMAPPED_READ;
    endcase
  endfunction

  always_comb begin
    logic [7:0] rdata;
    logic [2:0] e;
    rdata = 8'h00;
    e = 3'h0;
    t_next = t_reg;

    if (ev.scl_rise) begin
      unique case (t_reg.state)
        ST_ADDR, ST_REG, ST_WDATA: begin
          t_next.shreg = {t_reg.shreg[6:0], ev.sda};
          t_next.bitcnt = t_reg.bitcnt + 4'h1;
        end
        ST_RDATA: begin
          t_next.bitcnt = t_reg.bitcnt + 4'h1;
        end
        ST_RDATA_ACK: begin
          // A not-acknowledge ends the read burst; wait for stop.
          if (ev.sda) begin
            t_next.state = ST_IDLE;
          end
        end
        default: begin
        end
      endcase
    end

    if (ev.scl_fall) begin
      unique case (t_reg.state)
        ST_ADDR: begin
          if (t_reg.bitcnt == 4'h8) begin
            if (t_reg.shreg[7:1] == `DSM_I2C_ADDR) begin
              t_next.rw = t_reg.shreg[0];
              t_next.sda_oe = 1'b1;
              t_next.state = ST_ADDR_ACK;
            end else begin
              t_next.state = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK, ST_RDATA_ACK: begin
          if (t_reg.state == ST_RDATA_ACK || t_reg.rw) begin
            rdata = read_byte(t_reg.ptr, t_reg.hs, t_reg.ls, t_reg.fb);
            t_next.shreg = rdata;
            t_next.ptr = t_reg.ptr + 8'h01;
            t_next.sda_oe = ~rdata[7];
            t_next.bitcnt = 4'h0;
            t_next.state = ST_RDATA;
          end else begin
            t_next.sda_oe = 1'b0;
            t_next.bitcnt = 4'h0;
            t_next.state = ST_REG;
          end
        end
        ST_REG: begin
          if (t_reg.bitcnt == 4'h8) begin
            t_next.ptr = t_reg.shreg;
            t_next.sda_oe = 1'b1;
            t_next.state = ST_REG_ACK;
          end
        end
        ST_REG_ACK, ST_WDATA_ACK: begin
          t_next.sda_oe = 1'b0;
          t_next.bitcnt = 4'h0;
          t_next.state = ST_WDATA;
        end
        ST_WDATA: begin
          if (t_reg.bitcnt == 4'h8) begin
            // Each mapped byte lands in its own slice; unmapped bytes and bits 7 and 3 of the packed byte are dropped.
            unique case (t_reg.ptr)
              `DSM_REG_HS_LOW: t_next.hs[7:0] = t_reg.shreg;
              `DSM_REG_PACKED: begin
                t_next.ls = t_reg.shreg[`DSM_PK_LS_MSB:`DSM_PK_LS_LSB];
                t_next.hs[10:8] = t_reg.shreg[`DSM_PK_HS_MSB:`DSM_PK_HS_LSB];
              end
              `DSM_REG_FB_B0: t_next.fb[7:0] = t_reg.shreg;
              `DSM_REG_FB_B1: t_next.fb[15:8] = t_reg.shreg;
              `DSM_REG_FB_B2: t_next.fb[23:16] = t_reg.shreg;
              `DSM_REG_FB_B3: t_next.fb[31:24] = t_reg.shreg;
              `DSM_REG_FB_B4: t_next.fb[39:32] = t_reg.shreg;
              `DSM_REG_FB_TOP: t_next.fb[42:40] = t_reg.shreg[2:0];
              default: begin
              end
            endcase
            t_next.ptr = t_reg.ptr + 8'h01;
            t_next.sda_oe = 1'b1;
            t_next.state = ST_WDATA_ACK;
          end
        end
        ST_RDATA: begin
          if (t_reg.bitcnt == 4'h8) begin
            t_next.sda_oe = 1'b0;
            t_next.state = ST_RDATA_ACK;
          end else begin
            t_next.shreg = {t_reg.shreg[6:0], 1'b0};
            t_next.sda_oe = ~t_reg.shreg[6];
          end
        end
        default: begin
        end
      endcase
    end

    // Start and stop override any bit activity in the same cycle.
    if (ev.start) begin
      t_next.state = ST_ADDR;
      t_next.bitcnt = 4'h0;
      t_next.sda_oe = 1'b0;
    end else if (ev.stop) begin
      t_next.state = ST_IDLE;
      t_next.sda_oe = 1'b0;
    end

    // Decoded settings follow the stored bytes with one cycle of delay.
    // Nothing depends on speed grade, so a setting carries over unchanged.
    e = ls_exp(t_reg.ls);
    t_next.hs_out = t_reg.hs;
    t_next.ls_ratio_out = 6'h01 << e;
    t_next.fb_int_out = t_reg.fb[`DSM_FB_W-1:`DSM_FB_FRAC_W];
    t_next.fb_frac_out = t_reg.fb[`DSM_FB_FRAC_W-1:0];
    t_next.total_div_out = {5'h00, t_reg.hs} << e;
  end

  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      t_reg <= TOP_RESET;
    end else begin
      t_reg <= t_next;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = t_reg.sda_oe;
  assign high_speed_divider = t_reg.hs_out;
  assign low_speed_divider_ratio = t_reg.ls_ratio_out;
  assign feedback_integer_part = t_reg.fb_int_out;
  assign feedback_fraction_part = t_reg.fb_frac_out;
  assign total_output_divide = t_reg.total_div_out;

endmodule

`default_nettype wire

// ---- design/dsm_unused_guard.sv ----
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ---- tb/dsm_top_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "dsm_params.svh"
module dsm_top_chk (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [10:0] high_speed_divider,
  input wire logic [5:0] low_speed_divider_ratio,
  input wire logic [10:0] feedback_integer_part,
  input wire logic [31:0] feedback_fraction_part,
  input wire logic [15:0] total_output_divide
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_rst_vals;
    high_speed_divider == `DSM_HS_RESET && low_speed_divider_ratio == 6'h01 &&
      feedback_integer_part == 11'h047 && feedback_fraction_part == 32'he756e62a;
  endsequence
  sequence s_rst_clear;
    !sda_oe && total_output_divide == 16'h0000;
  endsequence
  chk_reset_vals: assert property ($rose(arst_n) |-> ##[2:6] s_rst_vals)
    else $error("reset divider values wrong");
  chk_reset_zero: assert property ($rose(arst_n) |-> s_rst_clear)
    else $error("outputs not clear in reset");
  chk_total_prod: assert property (total_output_divide ==
    16'(high_speed_divider) * 16'(low_speed_divider_ratio))
    else $error("total divide not product");
  chk_ratio_legal: assert property ($onehot0(low_speed_divider_ratio) &&
    low_speed_divider_ratio < 6'h21)
    else $error("low ratio not a power of two");
  chk_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line moved with clock high");
  chk_oe_stands: assert property ($rose(sda_oe) |-> sda_oe [*8])
    else $error("data line pull too short");
  // The feedback fraction may only move after a bus byte, never from an idle bus.
  // The reset chain's own reload lands four samples after release, so it is left out.
  chk_write_scl: assert property ((!$stable(feedback_fraction_part) &&
    $past(arst_n, 4)) |-> $past(!scl_in, 2))
    else $error("divider changed without bus clock");
  chk_sda_low_only: assert property (sda_oe |-> sda_out == 1'b0)
    else $error("data line driven high");
endmodule
bind dsm_top dsm_top_chk u_chk (.clock(clock), .arst_n(arst_n), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .high_speed_divider(high_speed_divider), .low_speed_divider_ratio(low_speed_divider_ratio),
  .feedback_integer_part(feedback_integer_part),
  .feedback_fraction_part(feedback_fraction_part), .total_output_divide(total_output_divide));
`default_nettype wire

// ---- tb/dsm_host.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "dsm_params.svh"
module dsm_host (
  input wire logic clock,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Phases of 8 cycles leave room for the device's 3-cycle answer delay.
  task automatic bitx(input logic b, output logic r);
    sda_low <= !b;
    tick(8);
    scl <= 1'b1;
    tick(4);
    r = sda;
    tick(4);
    scl <= 1'b0;
    tick(1);
  endtask
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
    output logic ack);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(mack, ack);
  endtask
  task automatic start();
    sda_low <= 1'b0;
    tick(8);
    scl <= 1'b1;
    tick(8);
    sda_low <= 1'b1;
    tick(8);
    scl <= 1'b0;
    tick(8);
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    tick(8);
    scl <= 1'b1;
    tick(8);
    sda_low <= 1'b0;
    tick(8);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d[$],
    output logic nack);
    logic [7:0] q;
    logic k;
    start();
    xfer({a, 1'b0}, 1'b1, q, nack);
    xfer(p, 1'b1, q, k);
    foreach (d[i]) xfer(d[i], 1'b1, q, k);
    stop();
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] q);
    logic k;
    start();
    xfer({`DSM_I2C_ADDR, 1'b0}, 1'b1, q, k);
    xfer(p, 1'b1, q, k);
    start();
    xfer({`DSM_I2C_ADDR, 1'b1}, 1'b1, q, k);
    xfer(8'hff, 1'b1, q, k);
    stop();
  endtask
  // The host acknowledges the first byte, so the pointer walks on to a second one.
  task automatic rd2(input logic [7:0] p, output logic [7:0] q0, output logic [7:0] q1);
    logic k;
    start();
    xfer({`DSM_I2C_ADDR, 1'b0}, 1'b1, q0, k);
    xfer(p, 1'b1, q0, k);
    start();
    xfer({`DSM_I2C_ADDR, 1'b1}, 1'b1, q0, k);
    xfer(8'hff, 1'b0, q0, k);
    xfer(8'hff, 1'b1, q1, k);
    stop();
  endtask
endmodule
`default_nettype wire

// ---- tb/divider_setting_mapping_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "dsm_params.svh"
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin errors++; \
  $display("unexpected %s exp %h got %h", nm, e, s); end end
module divider_setting_mapping_tb;
  import dsm_pkg::*;
  typedef struct packed {logic [7:0] pk; logic [5:0] ratio;} dsm_row_s;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic scl;
  logic sda_low;
  logic sda_out;
  logic sda_oe;
  logic [10:0] hs;
  logic [10:0] fi;
  logic [5:0] lr;
  logic [31:0] ff;
  logic [15:0] tot;
  wire logic sda;
  integer errors = 0;
  integer n_compared = 0;
  dsm_row_s rows [8] = '{'{8'h00, 6'h01}, '{8'h19, 6'h02}, '{8'h22, 6'h04},
    '{8'hb3, 6'h08}, '{8'h44, 6'h10}, '{8'h5d, 6'h20}, '{8'h6e, 6'h20}, '{8'hff, 6'h20}};
  assign sda = !sda_low && (sda_oe ? sda_out : 1'b1);
  dsm_host u_host (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low));
  dsm_top dut (.clock(clock), .arst_n(arst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .high_speed_divider(hs),
    .low_speed_divider_ratio(lr), .feedback_integer_part(fi),
    .feedback_fraction_part(ff), .total_output_divide(tot));
  initial begin
    forever #5 clock = ~clock;
  end
  task automatic tally_and_finish();
    if (errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk_rst();
    `CHK("hs", 11'h046, hs);
    `CHK("ratio", 6'h01, lr);
    `CHK("int", 11'h047, fi);
    `CHK("frac", 32'he756e62a, ff);
    `CHK("total", 16'h0046, tot);
  endtask
  initial begin
    repeat (100000) @(posedge clock);
    errors++;
    tally_and_finish();
  end
  initial begin
    logic [7:0] q;
    logic [7:0] q2;
    logic [7:0] d[$];
    logic k;
    logic [10:0] h;
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    repeat (8) @(posedge clock);
    chk_rst();
    foreach (rows[i]) begin
      d = {rows[i].pk};
      u_host.wr(`DSM_I2C_ADDR, `DSM_REG_PACKED, d, k);
      h = {rows[i].pk[2:0], 8'h46};
      `CHK("ack", 1'b0, k);
      `CHK("hs", h, hs);
      `CHK("ratio", rows[i].ratio, lr);
      `CHK("total", 16'(h) * 16'(rows[i].ratio), tot);
      u_host.rd(`DSM_REG_PACKED, q);
      `CHK("packed", rows[i].pk & 8'h77, q);
    end
    // Plan from the lowest oscillator: divider 70, ratio 1, feedback fraction truncated.
    d = {8'h46, 8'h00, 8'h00, 8'h2a, 8'he6, 8'h56, 8'he7, 8'h47, 8'h00};
    u_host.wr(`DSM_I2C_ADDR, `DSM_REG_HS_LOW, d, k);
    `CHK("ack", 1'b0, k);
    chk_rst();
    // One burst crosses the unmapped gap; the divider value is even above 33.
    d = {8'h9c, 8'h03, 8'haa, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'hfe};
    u_host.wr(`DSM_I2C_ADDR, `DSM_REG_HS_LOW, d, k);
    `CHK("hs", 11'h39c, hs);
    `CHK("total", 16'h039c, tot);
    `CHK("int", 11'h655, fi);
    `CHK("frac", 32'h44332211, ff);
    u_host.rd(`DSM_REG_FB_TOP, q);
    `CHK("top", 8'h06, q);
    u_host.rd2(`DSM_REG_FB_B4, q, q2);
    `CHK("b4", 8'h55, q);
    `CHK("top next", 8'h06, q2);
    u_host.rd(8'h19, q);
    `CHK("gap", 8'h00, q);
    u_host.wr(7'h2a, `DSM_REG_HS_LOW, d, k);
    `CHK("nack", 1'b1, k);
    `CHK("hs", 11'h39c, hs);
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    `CHK("rst hs", 11'h000, hs);
    arst_n <= 1'b1;
    repeat (8) @(posedge clock);
    chk_rst();
    tally_and_finish();
  end
endmodule
`default_nettype wire
